// ### bets_top.v
`timescale 1ns/10ps
`include "bets_defs.vh"
`default_nettype none
module bets_top (
  input wire aclk,
  input wire aresetn,
  input wire tx_gate,
  input wire rx_gate,
  output reg tx_analog_on,
  output reg tx_if_on,
  output reg tx_antenna_on,
  output reg tx_zero_fill,
  output reg rx_analog_on,
  output reg rx_if_on,
  output reg rx_lna_on,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam integer SETUP_INT = `BETS_SETUP_CYC;
  localparam integer RETUNE_INT = `BETS_SETUP_RETUNE_CYC;
  // both counts fit the counter width, so the cut drops only zeros
  localparam [`BETS_CW-1:0] SETUP_CYC = SETUP_INT[`BETS_CW-1:0];
  localparam [`BETS_CW-1:0] RETUNE_CYC = RETUNE_INT[`BETS_CW-1:0];
  // delay index: 0 tx r2a, 1 tx r2on, 2 tx f2off, 3 tx hold,
  // 4 rx r2a, 5 rx r2on, 6 rx f2off, 7 rx hold, 8 tx setup, 9 rx setup
  localparam NDLY = 10;

  reg [1:0] ctrl;
  reg [23:0] d_tx_r2a, d_tx_r2on, d_tx_f2off, d_tx_hold_prog;
  reg [23:0] d_rx_r2a, d_rx_r2on, d_rx_f2off, d_rx_hold;
  reg tx_gate_q, rx_gate_q;
  reg tx_if_pend;
  wire [23:0] setup_now;
  wire tx_rise, tx_fall, rx_rise, rx_fall;
  wire [NDLY-1:0] dly_start, dly_done, dly_busy;
  wire [24*NDLY-1:0] dly_count;

  assign setup_now = ctrl[`BETS_CTRL_RETUNE] ? RETUNE_CYC : SETUP_CYC;
  assign tx_rise = tx_gate & ~tx_gate_q;
  assign tx_fall = ~tx_gate & tx_gate_q;
  assign rx_rise = rx_gate & ~rx_gate_q;
  assign rx_fall = ~rx_gate & rx_gate_q;

  // tx hold delay is ignored; hardware uses zero for it
  assign dly_start = {dly_done[4], dly_done[0], rx_fall, rx_fall,
    rx_rise, rx_rise, tx_fall, tx_fall, tx_rise, tx_rise};
  assign dly_count = {setup_now, setup_now, d_rx_hold, d_rx_f2off,
    d_rx_r2on, d_rx_r2a, 24'h000000, d_tx_f2off, d_tx_r2on, d_tx_r2a};

  genvar gi;
  generate
    for (gi = 0; gi < NDLY; gi = gi + 1) begin : g_dly
      bets_delay u_dly (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(dly_start[gi]),
        .count(dly_count[24*gi +: 24]),
        .done(dly_done[gi]),
        .busy(dly_busy[gi])
      );
    end
  endgenerate

  // transmit sequencing from gate edges
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_gate_q <= 1'b0;
      tx_analog_on <= 1'b0;
      tx_if_on <= 1'b0;
      tx_antenna_on <= 1'b0;
      tx_zero_fill <= 1'b0;
      tx_if_pend <= 1'b0;
    end else begin
      tx_gate_q <= tx_gate;
      if (tx_rise) begin
        tx_if_on <= 1'b1;
        tx_zero_fill <= 1'b0;
        tx_if_pend <= 1'b0;
      end else if (dly_done[3]) begin
        tx_if_on <= 1'b0;
      end
      if (tx_fall)
        tx_if_pend <= 1'b1;
      if (dly_done[0])
        tx_analog_on <= 1'b1;
      // zero antenna delay waits for setup end instead
      if ((dly_done[1] && !dly_busy[8] && tx_analog_on) ||
          (dly_done[8] && tx_gate_q && !dly_busy[1]))
        tx_antenna_on <= 1'b1;
      // zeros flow once interface data has drained
      if (dly_done[3] && dly_busy[2])
        tx_zero_fill <= 1'b1;
      if (dly_done[2]) begin
        tx_antenna_on <= 1'b0;
        tx_zero_fill <= 1'b0;
      end
      // analog powers down once interface is off and fall-to-off delay is over
      if (tx_if_pend && !tx_if_on && !dly_busy[2] && !tx_gate_q) begin
        tx_analog_on <= 1'b0;
        tx_if_pend <= 1'b0;
      end
    end
  end

  // receive sequencing; interface follows analog power-down
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_gate_q <= 1'b0;
      rx_analog_on <= 1'b0;
      rx_if_on <= 1'b0;
      rx_lna_on <= 1'b0;
    end else begin
      rx_gate_q <= rx_gate;
      if (dly_done[4])
        rx_analog_on <= 1'b1;
      if (dly_done[5]) begin
        rx_if_on <= 1'b1;
        rx_lna_on <= ctrl[`BETS_CTRL_LNA_OWN];
      end
      if (dly_done[6]) begin
        rx_analog_on <= 1'b0;
        rx_lna_on <= 1'b0;
      end
      if (dly_done[7] && !rx_analog_on && !dly_done[6] && !dly_busy[6])
        rx_if_on <= 1'b0;
      else if (!rx_gate_q && !dly_busy[7] && !rx_analog_on && rx_if_on)
        rx_if_on <= 1'b0;
    end
  end

  // axi4-lite write: take address and data in any order
  reg [7:0] aw_addr;
  reg aw_have, w_have;
  reg [31:0] w_data;
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BETS_RESP_OKAY;
      ctrl <= 2'h0;
      d_tx_r2a <= 24'h000000;
      d_tx_r2on <= 24'h000000;
      d_tx_hold_prog <= 24'h000000;
      d_tx_f2off <= 24'h000000;
      d_rx_r2a <= 24'h000000;
      d_rx_r2on <= 24'h000000;
      d_rx_f2off <= 24'h000000;
      d_rx_hold <= 24'h000000;
    end else begin
      s_axi_awready <= !aw_have && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_have && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (aw_have && w_have && !s_axi_bvalid) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `BETS_RESP_OKAY;
        case (aw_addr)
          `BETS_A_CTRL: ctrl <= w_data[1:0];
          `BETS_A_TX_R2A: d_tx_r2a <= w_data[23:0];
          `BETS_A_TX_R2ON: d_tx_r2on <= w_data[23:0];
          `BETS_A_TX_HOLD: d_tx_hold_prog <= w_data[23:0];
          `BETS_A_TX_F2OFF: d_tx_f2off <= w_data[23:0];
          `BETS_A_RX_R2A: d_rx_r2a <= w_data[23:0];
          `BETS_A_RX_R2ON: d_rx_r2on <= w_data[23:0];
          `BETS_A_RX_F2OFF: d_rx_f2off <= w_data[23:0];
          `BETS_A_RX_HOLD: d_rx_hold <= w_data[23:0];
          `BETS_A_SETUP, `BETS_A_STATUS: s_axi_bresp <= `BETS_RESP_OKAY;
          default: s_axi_bresp <= `BETS_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi4-lite read: one cycle from address to data
  reg [31:0] next_rdata;
  reg next_rerr;
  always @* begin
    next_rerr = 1'b0;
    case (s_axi_araddr)
      `BETS_A_CTRL: next_rdata = {30'h00000000, ctrl};
      `BETS_A_TX_R2A: next_rdata = {8'h00, d_tx_r2a};
      `BETS_A_TX_R2ON: next_rdata = {8'h00, d_tx_r2on};
      `BETS_A_TX_HOLD: next_rdata = {8'h00, d_tx_hold_prog};
      `BETS_A_TX_F2OFF: next_rdata = {8'h00, d_tx_f2off};
      `BETS_A_RX_R2A: next_rdata = {8'h00, d_rx_r2a};
      `BETS_A_RX_R2ON: next_rdata = {8'h00, d_rx_r2on};
      `BETS_A_RX_F2OFF: next_rdata = {8'h00, d_rx_f2off};
      `BETS_A_RX_HOLD: next_rdata = {8'h00, d_rx_hold};
      `BETS_A_SETUP: next_rdata = {8'h00, setup_now};
      `BETS_A_STATUS: next_rdata = {25'h0000000, tx_zero_fill,
        rx_lna_on, rx_if_on, rx_analog_on, tx_antenna_on, tx_if_on,
        tx_analog_on};
      default: begin
        next_rdata = 32'h00000000;
        next_rerr = 1'b1;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `BETS_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rerr ? `BETS_RESP_SLVERR : `BETS_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### bets_defs.vh
// How it works
// - transmit interface hold delay forced to zero
// - antenna leaves transmit after fall-to-off delay
// - equal delays: interface off before analog down
// - zeros transmitted after data until delay expires
// - zero analog delay powers up immediately
// - zero antenna delay switches at setup end
// - receive gate sequences analog, then interface and amplifier together
// - setup time reported as 1600 or 151600 cycles (8 or 758 us)
// - receive interface off after analog power-down
`ifndef BETS_DEFS_VH
`define BETS_DEFS_VH
`define BETS_CLK_MHZ 200
`define BETS_SETUP_US 8
`define BETS_SETUP_RETUNE_US 758
`define BETS_SETUP_CYC (`BETS_SETUP_US * `BETS_CLK_MHZ)
`define BETS_SETUP_RETUNE_CYC (`BETS_SETUP_RETUNE_US * `BETS_CLK_MHZ)
`define BETS_CW 24
// register byte addresses
`define BETS_A_CTRL 8'h00
`define BETS_A_TX_R2A 8'h04
`define BETS_A_TX_R2ON 8'h08
`define BETS_A_TX_HOLD 8'h0C
`define BETS_A_TX_F2OFF 8'h10
`define BETS_A_RX_R2A 8'h14
`define BETS_A_RX_R2ON 8'h18
`define BETS_A_RX_F2OFF 8'h1C
`define BETS_A_RX_HOLD 8'h20
`define BETS_A_SETUP 8'h24
`define BETS_A_STATUS 8'h28
// control fields
`define BETS_CTRL_RETUNE 0
`define BETS_CTRL_LNA_OWN 1
`define BETS_RESP_OKAY 2'h0
`define BETS_RESP_SLVERR 2'h2
`endif

// ### bets_delay.v
`timescale 1ns/10ps
`default_nettype none
// down-counter: loaded on start, pulses done when it reaches zero
module bets_delay (
  input wire aclk,
  input wire aresetn,
  input wire start,
  input wire [23:0] count,
  output reg done,
  output reg busy
);
  reg [23:0] remain;

  // a fresh start always reloads, so the latest edge wins
  always @(posedge aclk) begin
    if (!aresetn) begin
      remain <= 24'h000000;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (start) begin
      remain <= count;
      busy <= (count != 24'h000000);
      done <= (count == 24'h000000);
    end else if (busy) begin
      remain <= remain - 24'h000001;
      busy <= (remain != 24'h000001);
      done <= (remain == 24'h000001);
    end else begin
      done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### bets_bb_model.sv
`timescale 1ns/10ps
`default_nettype none
// baseband side: owns both burst gates, switches only after a clock edge
module bets_bb_model (
  input wire logic aclk,
  output logic tx_gate,
  output logic rx_gate
);
  initial begin
    tx_gate = 1'b0;
    rx_gate = 1'b0;
  end
  // gate held for the whole burst so the device sees clean edges
  task burst(input bit rx, input int len);
    @(posedge aclk);
    // guard words would go out with the gate; data is not modelled here
    if (rx) rx_gate <= 1'b1;
    else tx_gate <= 1'b1;
    repeat (len) @(posedge aclk);
    rx_gate <= 1'b0;
    tx_gate <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### bets_checker.sv
`timescale 1ns/10ps
`default_nettype none
module bets_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tx_gate,
  input wire logic tx_analog_on,
  input wire logic tx_if_on,
  input wire logic tx_antenna_on,
  input wire logic tx_zero_fill,
  input wire logic rx_analog_on,
  input wire logic rx_if_on,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  // gate edges are registered, so outputs may trail by two edges
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_if_fall: assert property ($fell(tx_gate) |-> ##[1:3] !tx_if_on)
    else $error("tx interface held after gate fall");
  chk_if_idle: assert property (!tx_gate [*3] |-> !tx_if_on)
    else $error("tx interface on without gate");
  chk_if_rise: assert property ($rose(tx_gate) |-> ##[1:3] tx_if_on)
    else $error("tx interface late after gate rise");
  chk_down_order: assert property ($fell(tx_analog_on) |-> !$past(tx_if_on))
    else $error("tx analog down before interface off");
  chk_rx_order: assert property ($fell(rx_if_on) |-> !rx_analog_on)
    else $error("rx interface off before analog down");
  chk_zero_fill: assert property (tx_zero_fill |-> !tx_if_on)
    else $error("zero fill while interface active");
  // the host follows this advisory flag, so it must sit inside analog power
  chk_ant_window: assert property (tx_antenna_on |-> tx_analog_on)
    else $error("antenna flag outside analog power window");
  // no new request is accepted while an answer waits
  chk_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while response pending");
  chk_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
endmodule
bind bets_top bets_checker i_chk (.aclk, .aresetn, .tx_gate, .tx_analog_on,
  .tx_if_on, .tx_antenna_on, .tx_zero_fill, .rx_analog_on, .rx_if_on,
  .s_axi_awready,
  .s_axi_bvalid, .s_axi_arready, .s_axi_rvalid);
`default_nettype wire

// ### bets_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "bets_defs.vh"
module bets_top_tb;
  logic aclk = 0, aresetn = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, rd, v;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [1:0] rsp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [8:0] st;
  logic [8:0] st_q = 0;
  int fail_count = 0, n_checks = 0, seed = 59, cyc = 0;
  int t_up[9] = '{default: 0}, t_dn[9] = '{default: 0};
  initial forever #2.5 aclk = ~aclk;
  bets_bb_model i_bets_bb_model (.aclk, .tx_gate(st[7]), .rx_gate(st[8]));
  bets_top i_bets_top (.aclk, .aresetn, .tx_gate(st[7]), .rx_gate(st[8]),
    .tx_analog_on(st[0]), .tx_if_on(st[1]), .tx_antenna_on(st[2]),
    .tx_zero_fill(st[3]), .rx_analog_on(st[4]), .rx_if_on(st[5]),
    .rx_lna_on(st[6]), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // cycle stamps of every rise and fall of gates and outputs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    st_q <= st;
    for (int i = 0; i < 9; i++) begin
      if (st[i] && !st_q[i]) t_up[i] <= cyc;
      if (!st[i] && st_q[i]) t_dn[i] <= cyc;
    end
  end
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [35:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  // registered edge detect leaves a little slack around each count
  task near(input int got, exp, input string m);
    chk(got >= exp - 1 && got <= exp + 2, 1'b1, m);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic b;
    b = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!b) begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 0;
      if (s_axi_bvalid) begin
        b = 1;
        s_axi_bready <= 0;
        rsp = s_axi_bresp;
      end
    end
    chk(b, 1'b1, "write got no response");
  endtask
  task rd_(input logic [7:0] a);
    logic b;
    b = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (!b) begin
      @(posedge aclk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 0;
      if (s_axi_rvalid) begin
        b = 1;
        s_axi_rready <= 0;
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
      end
    end
    chk(b, 1'b1, "read got no data");
  endtask
  task tx_case(input int r2a, r2on, f2off);
    wr(`BETS_A_TX_R2A, r2a);
    wr(`BETS_A_TX_R2ON, r2on);
    wr(`BETS_A_TX_HOLD, f2off & 7);
    wr(`BETS_A_TX_F2OFF, f2off);
    i_bets_bb_model.burst(0, 2000);
    repeat (f2off + 20) @(posedge aclk);
    near(t_up[0] - t_up[7], r2a + 2, "tx analog power-up time");
    near(t_up[2] - t_up[7], (r2on ? r2on : r2a + `BETS_SETUP_CYC) + 2,
      "tx antenna on time");
    near(t_dn[1] - t_dn[7], 1, "tx interface off time");
    near(t_dn[2] - t_dn[7], f2off + 2, "tx antenna off time");
    near(t_dn[0] - t_dn[7], f2off + 2, "tx analog power-down time");
    if (f2off > 0)
      near(t_up[3] - t_dn[7], 2, "tx zero fill start");
  endtask
  task rx_case(input int r2a, f2off, lna);
    int p, hold;
    p = t_up[6];
    hold = f2off + ($random(seed) & 15);
    wr(`BETS_A_CTRL, lna << 1);
    wr(`BETS_A_RX_R2A, r2a);
    wr(`BETS_A_RX_R2ON, r2a + `BETS_SETUP_CYC + 9);
    wr(`BETS_A_RX_F2OFF, f2off);
    wr(`BETS_A_RX_HOLD, hold);
    i_bets_bb_model.burst(1, 2000);
    repeat (hold + 20) @(posedge aclk);
    near(t_up[4] - t_up[8], r2a + 2, "rx analog on time");
    near(t_up[5] - t_up[8], r2a + `BETS_SETUP_CYC + 11, "rx if on");
    near(t_dn[4] - t_dn[8], f2off + 2, "rx analog off time");
    near(t_dn[5] - t_dn[8], hold + 2, "rx interface off time");
    chk(t_up[6] > p, lna, "amplifier control");
  endtask
  initial begin
    #200000;
    fail_count++;
    summarize;
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    rd_(`BETS_A_SETUP);
    chk(rd, `BETS_SETUP_CYC, "setup time");
    wr(`BETS_A_CTRL, 32'h1);
    rd_(`BETS_A_SETUP);
    chk(rd, `BETS_SETUP_RETUNE_CYC, "retune setup time");
    wr(8'h30, 32'h5);
    chk(rsp, `BETS_RESP_SLVERR, "unmapped write");
    rd_(8'h30);
    chk({rd, rsp}, {32'h0, `BETS_RESP_SLVERR}, "unmapped read");
    v = $random(seed);
    wr(`BETS_A_TX_HOLD, v);
    rd_(`BETS_A_TX_HOLD);
    chk(rd, v & 32'h00FFFFFF, "delay readback");
    wr(`BETS_A_CTRL, 32'h0);
    tx_case(0, 0, 0);
    for (int i = 0; i < 3; i++) begin
      v = $random(seed) & 63;
      tx_case(v, v + `BETS_SETUP_CYC + ($random(seed) & 15),
        $random(seed) & 31);
    end
    // latency equal to delay plus setup, fall-to-off past the latency
    tx_case(5, 5 + `BETS_SETUP_CYC, 5 + `BETS_SETUP_CYC + 7);
    rx_case($random(seed) & 31, $random(seed) & 31, 1);
    rx_case(0, 0, 0);
    summarize;
  end
endmodule
`default_nettype wire
